// ### common/rail_override_pkg.sv
// Package: register map, field positions, rail indices and carrier types for the override bank
package rail_override_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] STEP_DOWN_CTRL_ADDR = 8'h9C;
  localparam logic [7:0] FORCE_OFF_ADDR      = 8'h9F;
  localparam logic [7:0] FORCE_ON_FIRST_ADDR = 8'hA0;
  localparam logic [7:0] FORCE_ON_LEVEL_ADDR = 8'hA1;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SD_FORCE_OFF_LSB   = 0;  // Step-down 1..3 force-off, bits 2:0
  localparam int SD_MODE_LSB        = 3;  // Step-down 1..3 mode, bits 5:3
  localparam logic [7:0] SD_CTRL_RW_MASK  = 8'h3F;
  localparam int OFF_TERM_BIT       = 4;
  localparam int OFF_SW_A1_BIT      = 5;
  localparam int OFF_SW_B1_BIT      = 6;
  localparam int OFF_SHARED_BIT     = 7;
  localparam int ON2_LDO3_BIT       = 0;
  localparam int ON2_SW_B1_BIT      = 1;
  localparam int ON2_SHARED_BIT     = 2;
  localparam int ON2_TERM_BIT       = 3;
  localparam int LEVEL_LSB          = 4;  // General outputs 1..4 on bits 7:4

  // ****************************************************************
  // Rail indices on the enable vectors
  // ****************************************************************
  localparam int RAIL_COUNT   = 13;
  localparam int RAIL_SW_A1   = 6;
  localparam int RAIL_LDO2    = 7;
  localparam int RAIL_LDO3    = 8;
  localparam int RAIL_SW_B1   = 9;
  localparam int RAIL_SW_B2   = 10;
  localparam int RAIL_LDO1    = 11;
  localparam int RAIL_TERM    = 12;
  localparam int GPO_COUNT    = 4;

  // ****************************************************************
  // Reset values and carriers
  // ****************************************************************
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] force_on_level;  // 0xA1
    logic [7:0] force_on_first;  // 0xA0
    logic [7:0] force_off;       // 0x9F
    logic [7:0] step_down_ctrl;  // 0x9C
  } reg_image_t;

  typedef struct packed {
    logic       shared_is_b2;    // Shared bits steer load switch B2, else aux LDO 1
    logic [3:0] gpo_host;        // Output is host-controlled rather than power-good tree
    logic [2:0] gpo_push_pull;   // Outputs 1..3 push-pull when set; output 4 is always open-drain
  } otp_config_t;

  typedef struct packed {
    reg_image_t                  regs;
    logic                        load_pending;
    logic [7:0]                  rdata;
    logic [RAIL_COUNT-1:0]       rail_en;
    logic [GPO_COUNT-1:0]        gpo_level;
    logic [GPO_COUNT-1:0]        gpo_oe;
  } state_t;

endpackage : rail_override_pkg

// ### design/rail_enable_override_regs.sv
// Rail force-off / force-on override registers and host-controlled general outputs
`timescale 1ns/1ps

module rail_enable_override_regs (
  input  wire logic                                     CLK_IN,
  input  wire logic                                     RST_IN,
  input  wire logic                                     REG_WR_IN,
  input  wire logic                                     REG_RD_IN,
  input  wire logic [7:0]                               REG_ADDR_IN,
  input  wire logic [7:0]                               REG_WDATA_IN,
  input  wire rail_override_pkg::reg_image_t            OTP_IMAGE_IN,
  input  wire rail_override_pkg::otp_config_t           OTP_CONFIG_IN,
  input  wire logic [2:0]                               EXT_FORCE_OFF_IN,
  input  wire logic [1:0]                               AUX_FORCE_OFF_IN,
  input  wire logic [rail_override_pkg::RAIL_COUNT-1:0] SEQ_EN_IN,
  input  wire logic [rail_override_pkg::GPO_COUNT-1:0]  PG_TREE_IN,
  output logic [7:0]                                    REG_RDATA_OUT,
  output logic [rail_override_pkg::RAIL_COUNT-1:0]      RAIL_EN_OUT,
  output logic [rail_override_pkg::GPO_COUNT-1:0]       GPO_OUT,
  output logic [rail_override_pkg::GPO_COUNT-1:0]       GPO_OE_OUT
);
  import rail_override_pkg::*;

  state_t state_reg;
  state_t state_next;
  logic [RAIL_COUNT-1:0] off_vec;
  logic [RAIL_COUNT-1:0] on_vec;
  logic [GPO_COUNT-1:0]  lvl_sel;
  logic [GPO_COUNT-1:0]  pp_vec;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Effective enable of one rail: force-off gates everything
  function automatic logic rail_enable(input logic off_n, input logic on, input logic seq);
    rail_enable = off_n & (on | seq);
  endfunction : rail_enable

  // Register read mux, used only for the host read data path
  function automatic logic [7:0] read_reg(input reg_image_t r, input logic [7:0] a);
    unique case (a)
      STEP_DOWN_CTRL_ADDR: read_reg = r.step_down_ctrl & SD_CTRL_RW_MASK;
      FORCE_OFF_ADDR:      read_reg = r.force_off;
      FORCE_ON_FIRST_ADDR: read_reg = r.force_on_first;
      FORCE_ON_LEVEL_ADDR: read_reg = r.force_on_level;
      default:             read_reg = REG_RESET;   // Unmapped offsets read as zero
    endcase
  endfunction : read_reg

  // ****************************************************************
  // Per-rail force vectors
  // ****************************************************************
  // Unselected half of the shared pair sees no override at all, so it
  // stays under pure pin/sequencer control
  always_comb begin
    off_vec = '1;
    on_vec  = '0;
    off_vec[2:0] = state_reg.regs.step_down_ctrl[SD_FORCE_OFF_LSB +: 3];
    off_vec[5:3] = EXT_FORCE_OFF_IN;
    off_vec[RAIL_LDO2] = AUX_FORCE_OFF_IN[0];
    off_vec[RAIL_LDO3] = AUX_FORCE_OFF_IN[1];
    off_vec[RAIL_SW_B1] = state_reg.regs.force_off[OFF_SW_B1_BIT];
    off_vec[RAIL_SW_A1] = state_reg.regs.force_off[OFF_SW_A1_BIT];
    off_vec[RAIL_TERM] = state_reg.regs.force_off[OFF_TERM_BIT];
    on_vec[7:0] = state_reg.regs.force_on_first;
    on_vec[RAIL_LDO3] = state_reg.regs.force_on_level[ON2_LDO3_BIT];
    on_vec[RAIL_SW_B1] = state_reg.regs.force_on_level[ON2_SW_B1_BIT];
    on_vec[RAIL_TERM] = state_reg.regs.force_on_level[ON2_TERM_BIT];
    if (OTP_CONFIG_IN.shared_is_b2) begin
      off_vec[RAIL_SW_B2] = state_reg.regs.force_off[OFF_SHARED_BIT];
      on_vec[RAIL_SW_B2]  = state_reg.regs.force_on_level[ON2_SHARED_BIT];
    end else begin
      off_vec[RAIL_LDO1] = state_reg.regs.force_off[OFF_SHARED_BIT];
      on_vec[RAIL_LDO1]  = state_reg.regs.force_on_level[ON2_SHARED_BIT];
    end
  end

  // Output 4 is always open-drain; 1..3 per factory setting
  assign pp_vec  = {1'b0, OTP_CONFIG_IN.gpo_push_pull};
  // Host-owned outputs take the level bit, the rest follow their tree
  assign lvl_sel = (state_reg.regs.force_on_level[LEVEL_LSB +: GPO_COUNT] &
                    OTP_CONFIG_IN.gpo_host)
                 | (PG_TREE_IN & ~OTP_CONFIG_IN.gpo_host);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.load_pending = 1'b0;
    if (state_reg.load_pending) begin
      // Factory image loaded one cycle after reset; tree-owned level bits cleared
      state_next.regs = OTP_IMAGE_IN;
      state_next.regs.step_down_ctrl = OTP_IMAGE_IN.step_down_ctrl & SD_CTRL_RW_MASK;
      state_next.regs.force_on_level[LEVEL_LSB +: GPO_COUNT] =
        OTP_IMAGE_IN.force_on_level[LEVEL_LSB +: GPO_COUNT] & OTP_CONFIG_IN.gpo_host;
    end else if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        STEP_DOWN_CTRL_ADDR: state_next.regs.step_down_ctrl = REG_WDATA_IN & SD_CTRL_RW_MASK;
        // Reserved low nibble is stored as written; host keeps it at zero
        FORCE_OFF_ADDR:      state_next.regs.force_off = REG_WDATA_IN;
        FORCE_ON_FIRST_ADDR: state_next.regs.force_on_first = REG_WDATA_IN;
        FORCE_ON_LEVEL_ADDR: state_next.regs.force_on_level = REG_WDATA_IN;
        default: ;
      endcase
    end
    if (REG_RD_IN) begin
      state_next.rdata = read_reg(state_reg.regs, REG_ADDR_IN);
    end
    // Enables are all forced off until the factory image has landed
    for (int i = 0; i < RAIL_COUNT; i++) begin
      state_next.rail_en[i] = rail_enable(off_vec[i], on_vec[i], SEQ_EN_IN[i]) &
                              ~state_reg.load_pending;
    end
    // Open-drain drives only for low; push-pull always drives
    state_next.gpo_level = lvl_sel;
    state_next.gpo_oe    = pp_vec | ~lvl_sel;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg <= '0;
      state_reg.load_pending <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign REG_RDATA_OUT = state_reg.rdata;
  assign RAIL_EN_OUT   = state_reg.rail_en;
  assign GPO_OUT       = state_reg.gpo_level;
  assign GPO_OE_OUT    = state_reg.gpo_oe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_write_off(int b);
    REG_WR_IN && !state_reg.load_pending && REG_ADDR_IN == FORCE_OFF_ADDR && !REG_WDATA_IN[b];
  endsequence

  // Host sets the aux LDO3 force-on bit while its own gate stays open for two edges
  sequence s_ldo3_on_write;
    REG_WR_IN && !state_reg.load_pending && REG_ADDR_IN == FORCE_ON_LEVEL_ADDR &&
      REG_WDATA_IN[ON2_LDO3_BIT] && AUX_FORCE_OFF_IN[1] ##1 AUX_FORCE_OFF_IN[1];
  endsequence

  // Force-off writes: the rail drops two edges after the write is taken
  a_b1_force_off: assert property (s_write_off(OFF_SW_B1_BIT) |=> ##1
      !RAIL_EN_OUT[RAIL_SW_B1])
    else $error("switch B1 still enabled after force-off");
  a_a1_force_off: assert property (s_write_off(OFF_SW_A1_BIT) |=> ##1
      !RAIL_EN_OUT[RAIL_SW_A1])
    else $error("switch A1 still enabled after force-off");
  a_term_force_off: assert property (s_write_off(OFF_TERM_BIT) |=> ##1
      !RAIL_EN_OUT[RAIL_TERM])
    else $error("termination LDO still enabled after force-off");
  a_shared_off_route: assert property (s_write_off(OFF_SHARED_BIT) |=> ##1
      !(OTP_CONFIG_IN.shared_is_b2 ? RAIL_EN_OUT[RAIL_SW_B2] : RAIL_EN_OUT[RAIL_LDO1]))
    else $error("shared rail still enabled after force-off");
  a_step_down_off: assert property (REG_WR_IN && !state_reg.load_pending &&
      REG_ADDR_IN == STEP_DOWN_CTRL_ADDR && !REG_WDATA_IN[0] |=> ##1 !RAIL_EN_OUT[0])
    else $error("step-down 1 still enabled after force-off");

  // Enable equation: sequencer by default, force-on lifts it, force-off always wins
  a_seq_follow: assert property (!state_reg.load_pending && off_vec[0] && !on_vec[0]
      |=> RAIL_EN_OUT[0] == $past(SEQ_EN_IN[0]))
    else $error("step-down 1 not following sequencer");
  a_force_on_hold: assert property (!state_reg.load_pending && on_vec[RAIL_SW_A1] &&
      off_vec[RAIL_SW_A1] |=> RAIL_EN_OUT[RAIL_SW_A1])
    else $error("forced-on switch A1 not enabled");
  a_ldo3_on_map: assert property (s_ldo3_on_write |=> RAIL_EN_OUT[RAIL_LDO3])
    else $error("aux LDO3 force-on bit not mapped");
  a_term_force_on: assert property (!state_reg.load_pending && on_vec[RAIL_TERM] &&
      off_vec[RAIL_TERM] |=> RAIL_EN_OUT[RAIL_TERM])
    else $error("forced-on termination LDO not enabled");
  a_unselected_free: assert property (OTP_CONFIG_IN.shared_is_b2 &&
      !state_reg.load_pending |=> RAIL_EN_OUT[RAIL_LDO1] == $past(SEQ_EN_IN[RAIL_LDO1]))
    else $error("unselected aux LDO1 not under sequencer control");
  a_enable_eq: assert property (!state_reg.load_pending |=> RAIL_EN_OUT[RAIL_SW_B1] ==
      $past(off_vec[RAIL_SW_B1] & (on_vec[RAIL_SW_B1] | SEQ_EN_IN[RAIL_SW_B1])))
    else $error("switch B1 enable equation broken");

  // General outputs: host-owned open-drain releases high, push-pull drives both levels; tree-owned ones follow their tree
  a_general_output_four_open_drain: assert property (OTP_CONFIG_IN.gpo_host[3] &&
      !state_reg.regs.force_on_level[7] |=> !GPO_OUT[3] && GPO_OE_OUT[3])
    else $error("output 4 not driven low");
  a_general_output_four_release: assert property (OTP_CONFIG_IN.gpo_host[3] &&
      state_reg.regs.force_on_level[7] |=> GPO_OUT[3] && !GPO_OE_OUT[3])
    else $error("output 4 not released high");
  a_gpo_host_level: assert property (OTP_CONFIG_IN.gpo_host[0] && !state_reg.load_pending
      |=> GPO_OUT[0] == $past(state_reg.regs.force_on_level[LEVEL_LSB]))
    else $error("output 1 level mismatch");
  a_gpo_push_pull: assert property (OTP_CONFIG_IN.gpo_host[0] &&
      OTP_CONFIG_IN.gpo_push_pull[0] |=> GPO_OE_OUT[0])
    else $error("push-pull output 1 not driving");
  a_tree_owned: assert property (!OTP_CONFIG_IN.gpo_host[1] |=>
      GPO_OUT[1] == $past(PG_TREE_IN[1]))
    else $error("tree-owned output 2 not following its tree");

  // A read returns the byte as it stood before the edge, even beside a write
  a_level_read_back: assert property (REG_RD_IN && REG_ADDR_IN == FORCE_ON_LEVEL_ADDR |=>
      REG_RDATA_OUT == $past(state_reg.regs.force_on_level))
    else $error("force-on and level register read mismatch");

endmodule : rail_enable_override_regs

// ### bench/rail_host_model.sv
// Host-side register master model that drives the override bank's strobe port
`timescale 1ns/1ps
module rail_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out
);
  import rail_override_pkg::*;

  // Idle bus at time zero
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // One-cycle write strobe; released bus shows inverted values so stale data never looks valid
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == FORCE_OFF_ADDR) d[3:0] = 4'h0;
    @(negedge clk_in);
    wr_out = 1'b1;
    addr_out = addr;
    wdata_out = d;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~addr;
    wdata_out = ~d;
  endtask : write

  // Read data is taken one cycle after the strobe edge
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_in);
    rd_out = 1'b1;
    addr_out = addr;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~addr;
    data = rdata_in;
  endtask : read
endmodule : rail_host_model

// ### bench/rail_enable_override_regs_test.sv
// Self-checking bench for the rail override register bank
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    miscompares++; \
  end \
end
module rail_enable_override_regs_test;
  import rail_override_pkg::*;
  logic                  clk;
  logic                  rst;
  logic                  wr;
  logic                  rd;
  logic [7:0]            addr;
  logic [7:0]            wdata;
  logic [7:0]            rdata;
  logic [7:0]            got;
  reg_image_t            otp;
  reg_image_t            img;
  otp_config_t           cfg;
  logic [2:0]            ext;
  logic [1:0]            aux;
  logic [RAIL_COUNT-1:0] seq;
  logic [3:0]            pg;
  logic [RAIL_COUNT-1:0] rails;
  logic [3:0]            gpo;
  logic [3:0]            gpo_oe;
  int                    miscompares;
  int                    check_count;
  // Case table: 9C writes other than 8'h3F carry reserved bits 7:6 to prove they are masked; 9F writes keep the reserved low nibble at zero
  logic [7:0]            t9c [5] = '{8'hFF, 8'h3F, 8'hFF, 8'hF8, 8'hC7};
  logic [7:0]            t9f [5] = '{8'hF0, 8'h00, 8'hF0, 8'h00, 8'hF0};
  logic [7:0]            ta0 [5] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  logic [7:0]            ta1 [5] = '{8'h50, 8'hF0, 8'h0F, 8'h0F, 8'h00};
  logic [RAIL_COUNT-1:0] tsq [5] = '{13'h1FFF, 13'h1FFF, 13'h0000, 13'h0000, 13'h0AAA};
  logic [7:0]            adr [4] = '{STEP_DOWN_CTRL_ADDR, FORCE_OFF_ADDR, FORCE_ON_FIRST_ADDR,
                                     FORCE_ON_LEVEL_ADDR};

  rail_enable_override_regs i_rail_enable_override_regs (
    .CLK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .OTP_IMAGE_IN(otp), .OTP_CONFIG_IN(cfg), .EXT_FORCE_OFF_IN(ext),
    .AUX_FORCE_OFF_IN(aux), .SEQ_EN_IN(seq), .PG_TREE_IN(pg), .REG_RDATA_OUT(rdata),
    .RAIL_EN_OUT(rails), .GPO_OUT(gpo), .GPO_OE_OUT(gpo_oe));

  rail_host_model i_rail_host_model (
    .clk_in(clk), .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata));

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Expected enables: force-off gates the OR of force-on and sequencer
  function automatic logic [RAIL_COUNT-1:0] exp_rails();
    logic       b2;
    logic [7:0] f;
    logic [7:0] n;
    b2 = cfg.shared_is_b2;
    f = img.force_off;
    n = img.force_on_level;
    return {f[4], b2 | f[7], ~b2 | f[7], f[6], aux, f[5], ext, img.step_down_ctrl[2:0]}
         & ({n[3], ~b2 & n[2], b2 & n[2], n[1], n[0], img.force_on_first} | seq);
  endfunction : exp_rails

  // Expected {output enable, level}; output 4 is always open-drain
  function automatic logic [7:0] exp_gpo();
    logic [3:0] lvl;
    logic [3:0] pp;
    pp = {1'b0, cfg.gpo_push_pull};
    for (int i = 0; i < 4; i++) lvl[i] = cfg.gpo_host[i] ? img.force_on_level[4+i] : pg[i];
    return {pp | ~lvl, lvl};
  endfunction : exp_gpo

  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  task automatic check_all();
    `CHK(rails, exp_rails())
    `CHK({gpo_oe, gpo}, exp_gpo())
    for (int k = 0; k < 4; k++) begin
      i_rail_host_model.read(adr[k], got);
      `CHK(got, img[8*k +: 8])
    end
  endtask : check_all

  // Reset with a new factory image; tree-owned level bits load as zero
  task automatic do_reset(input otp_config_t c, input reg_image_t o);
    @(negedge clk);
    rst = 1'b1;
    cfg = c;
    otp = o;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    img = o;
    img.step_down_ctrl = o.step_down_ctrl & SD_CTRL_RW_MASK;
    img.force_on_level[7:4] = o.force_on_level[7:4] & c.gpo_host;
    repeat (2) @(negedge clk);
    check_all();
  endtask : do_reset

  // Write all four registers with one idle cycle between strobes, then let the two-edge latency pass
  task automatic run_cases();
    for (int k = 0; k < 5; k++) begin
      seq = tsq[k];
      pg = tsq[k][3:0];
      i_rail_host_model.write(STEP_DOWN_CTRL_ADDR, t9c[k]);
      i_rail_host_model.write(FORCE_OFF_ADDR, t9f[k]);
      i_rail_host_model.write(FORCE_ON_FIRST_ADDR, ta0[k]);
      i_rail_host_model.write(FORCE_ON_LEVEL_ADDR, ta1[k]);
      img = {ta1[k], ta0[k], t9f[k], t9c[k] & SD_CTRL_RW_MASK};
      repeat (2) @(negedge clk);
      check_all();
    end
  endtask : run_cases

  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #1000000;
    miscompares++;
    results();
  end

  initial begin
    rst = 1'b1;
    otp = '0;
    cfg = '0;
    ext = 3'b110;
    aux = 2'b01;
    seq = '0;
    pg = 4'hA;
    miscompares = 0;
    check_count = 0;
    do_reset('{1'b0, 4'hF, 3'b101}, '{8'hA0, 8'h00, 8'hF0, 8'h07});
    run_cases();
    i_rail_host_model.write(8'h50, 8'hFF);
    i_rail_host_model.read(8'h50, got);
    `CHK(got, 8'h00)
    // Close aux LDO2 and open aux LDO3 so its force-on path is exercised
    ext = 3'b011;
    aux = 2'b10;
    do_reset('{1'b1, 4'h5, 3'b000}, '{8'hF0, 8'h00, 8'hF0, 8'h07});
    run_cases();
    results();
  end
endmodule : rail_enable_override_regs_test
